// ---- rtl/hamb_pkg.sv ----
package hamb_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] HAMB_CTRL_OFS  = 8'h00;
  localparam logic [7:0] HAMB_MODE_OFS  = 8'h04;
  localparam logic [7:0] HAMB_HOFS_OFS  = 8'h08;
  localparam logic [7:0] HAMB_FAST_OFS  = 8'h0C;
  localparam logic [7:0] HAMB_CREEP_OFS = 8'h10;
  localparam logic [7:0] HAMB_ACC_OFS   = 8'h14;
  localparam logic [7:0] HAMB_RISE_OFS  = 8'h18;
  localparam logic [7:0] HAMB_STAT_OFS  = 8'h1C;
  localparam logic [7:0] HAMB_REF_OFS   = 8'h20;
  localparam logic [7:0] HAMB_HOME_OFS  = 8'h24;
  localparam logic [7:0] HAMB_BSEL_OFS  = 8'h28;
  localparam logic [7:0] HAMB_BDAT_OFS  = 8'h2C;
  localparam logic [7:0] HAMB_MUX_OFS   = 8'h30;
  localparam logic [7:0] HAMB_ACT_OFS   = 8'h34;

  // ************************************************************
  // field positions, mode codes, limits and reset values
  // ************************************************************
  localparam int HAMB_CTRL_START_BIT = 0;
  localparam int HAMB_CTRL_ADOPT_BIT = 1;
  localparam int HAMB_CTRL_STOP_BIT  = 2;
  localparam logic [5:0]  HAMB_MODE_MAX    = 6'h23;
  localparam logic [5:0]  HAMB_MODE_ADOPT  = 6'h23;
  localparam logic [5:0]  HAMB_MODE_NONE   = 6'h00;
  localparam logic [31:0] HAMB_HOFS_RST    = 32'h0000_0000;
  localparam logic [31:0] HAMB_FAST_RST    = 32'h0002_8000;
  localparam logic [31:0] HAMB_CREEP_RST   = 32'h0000_8000;
  localparam logic [31:0] HAMB_ACC_RST     = 32'h0005_0000;
  localparam logic [11:0] HAMB_RISE_RST    = 12'h000;
  localparam logic [11:0] HAMB_RISE_MAX    = 12'h7D0;
  localparam logic [5:0]  HAMB_BLK_COUNT   = 6'h20;
  localparam logic [5:0]  HAMB_ACT_RST     = 6'h01;

  // block field codes in selector bits [10:8]
  typedef enum logic [2:0] {
    HAMB_F_TGT  = 3'h0,
    HAMB_F_SPD  = 3'h1,
    HAMB_F_ACC  = 3'h2,
    HAMB_F_DEC  = 3'h3,
    HAMB_F_MODE = 3'h4,
    HAMB_F_REPS = 3'h5,
    HAMB_F_NEXT = 3'h6,
    HAMB_F_DSIG = 3'h7
  } hamb_field_type;

  typedef enum logic [1:0] {
    HAMB_IDLE  = 2'h0,
    HAMB_FAST  = 2'h1,
    HAMB_CREEP = 2'h2,
    HAMB_DECEL = 2'h3
  } hamb_state_type;

endpackage

// ---- rtl/hamb_ctrl.sv ----
`timescale 1ns/1ns
module hamb_ctrl
  import hamb_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        lim_neg,
  input  wire logic        lim_pos,
  input  wire logic        home_sw,
  input  wire logic        enc_zero,
  input  wire logic [31:0] act_pos,
  input  wire logic        axis_still,
  output logic [31:0]      speed_cmd,
  output logic [31:0]      accel_cmd,
  output logic [11:0]      ramp_rise,
  output logic [31:0]      ref_pos,
  output logic             homing_done,
  output logic             homing_busy,
  output logic [7:0]       mux_idx,
  output logic [31:0]      blk_tgt,
  output logic [31:0]      blk_spd,
  output logic [31:0]      blk_acc,
  output logic [31:0]      blk_dec,
  output logic [7:0]       blk_mode,
  output logic [15:0]      blk_reps,
  output logic [5:0]       blk_next,
  output logic [7:0]       blk_dsig
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic                    pready;
    logic [31:0]             prdata;
    logic                    pslverr;
    logic [3:0]              s1;
    logic [3:0]              s2;
    logic [3:0]              s3;
    hamb_state_type          st;
    logic                    dir;
    logic [5:0]              mode;
    logic [31:0]             hofs;
    logic [31:0]             fast;
    logic [31:0]             creep;
    logic [31:0]             acc;
    logic [11:0]             rise;
    logic [31:0]             home;
    logic [31:0]             ref_pos;
    logic                    done;
    logic                    busy;
    logic [31:0]             spd_cmd;
    logic [10:0]             bsel;
    logic [7:0]              mux;
    logic [5:0]              act;
    logic [31:0][31:0]       tgt;
    logic [31:0][31:0]       spd;
    logic [31:0][31:0]       bacc;
    logic [31:0][31:0]       bdec;
    logic [31:0][7:0]        bmode;
    logic [31:0][15:0]       reps;
    logic [31:0][5:0]        next;
    logic [31:0][7:0]        dsig;
    logic [31:0]             o_tgt;
    logic [31:0]             o_spd;
    logic [31:0]             o_acc;
    logic [31:0]             o_dec;
    logic [7:0]              o_mode;
    logic [15:0]             o_reps;
    logic [5:0]              o_next;
    logic [7:0]              o_dsig;
  } hamb_state_type_s_type;

  hamb_state_type_s_type state_reg;
  hamb_state_type_s_type state_next;

  logic        acc_phase;
  logic        wr_en;
  logic        rd_en;
  logic        src_lvl;
  logic        src_edge;
  logic [3:0]  rise_e;
  logic [3:0]  fall_e;
  logic [5:0]  bidx;
  logic [4:0]  aidx;
  logic [31:0] rdat;
  logic        rerr;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    acc_phase  = psel & penable;
    // two-cycle access phase: the slave answers one cycle after penable rises
    state_next.pready = acc_phase & ~state_reg.pready;
    wr_en = acc_phase & state_reg.pready & pwrite;
    rd_en = acc_phase & ~state_reg.pready & ~pwrite;
    bidx  = state_reg.bsel[5:0];
    aidx  = 5'(state_reg.act - 6'h01);

    // inputs order {enc_zero, home_sw, lim_pos, lim_neg}; only s2/s3 are looked at
    state_next.s1 = {enc_zero, home_sw, lim_pos, lim_neg};
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    rise_e   = state_reg.s2 & ~state_reg.s3;
    fall_e   = ~state_reg.s2 & state_reg.s3;
    src_lvl  = state_reg.s2[state_reg.mode[1:0]];
    src_edge = state_reg.mode[3] ? fall_e[state_reg.mode[1:0]]
                                 : rise_e[state_reg.mode[1:0]];

    // ********** register read **********
    rdat = 32'h0000_0000;
    rerr = 1'b0;
    case (paddr)
      HAMB_CTRL_OFS:  rdat = 32'h0000_0000;
      HAMB_MODE_OFS:  rdat = {26'h0, state_reg.mode};
      HAMB_HOFS_OFS:  rdat = state_reg.hofs;
      HAMB_FAST_OFS:  rdat = state_reg.fast;
      HAMB_CREEP_OFS: rdat = state_reg.creep;
      HAMB_ACC_OFS:   rdat = state_reg.acc;
      HAMB_RISE_OFS:  rdat = {20'h0, state_reg.rise};
      HAMB_STAT_OFS:  rdat = {27'h0, state_reg.dir, state_reg.st, state_reg.busy,
                              state_reg.done};
      HAMB_REF_OFS:   rdat = state_reg.ref_pos;
      HAMB_HOME_OFS:  rdat = state_reg.home;
      HAMB_BSEL_OFS:  rdat = {21'h0, state_reg.bsel};
      HAMB_BDAT_OFS: begin
        if (bidx == 6'h00 || bidx > HAMB_BLK_COUNT) begin
          rerr = (bidx != 6'h00);
        end else begin
          case (hamb_field_type'(state_reg.bsel[10:8]))
            HAMB_F_TGT:  rdat = state_reg.tgt[5'(bidx - 6'h01)];
            HAMB_F_SPD:  rdat = state_reg.spd[5'(bidx - 6'h01)];
            HAMB_F_ACC:  rdat = state_reg.bacc[5'(bidx - 6'h01)];
            HAMB_F_DEC:  rdat = state_reg.bdec[5'(bidx - 6'h01)];
            HAMB_F_MODE: rdat = {24'h0, state_reg.bmode[5'(bidx - 6'h01)]};
            HAMB_F_REPS: rdat = {16'h0, state_reg.reps[5'(bidx - 6'h01)]};
            HAMB_F_NEXT: rdat = {26'h0, state_reg.next[5'(bidx - 6'h01)]};
            HAMB_F_DSIG: rdat = {24'h0, state_reg.dsig[5'(bidx - 6'h01)]};
            default:     rdat = 32'h0000_0000;
          endcase
        end
      end
      HAMB_MUX_OFS:   rdat = {24'h0, state_reg.mux};
      HAMB_ACT_OFS:   rdat = {26'h0, state_reg.act};
      default:        rerr = 1'b1;
    endcase
    if (acc_phase & ~state_reg.pready) begin
      state_next.prdata  = rd_en ? rdat : 32'h0000_0000;
      state_next.pslverr = rerr;
    end

    // ********** register write **********
    if (wr_en & ~rerr) begin
      case (paddr)
        HAMB_MODE_OFS:  if (pwdata[5:0] <= HAMB_MODE_MAX) state_next.mode = pwdata[5:0];
        HAMB_HOFS_OFS:  state_next.hofs = pwdata;
        // zero speeds and accelerations are refused: the axis could never finish
        HAMB_FAST_OFS:  if (pwdata != 32'h0) state_next.fast = pwdata;
        HAMB_CREEP_OFS: if (pwdata != 32'h0) state_next.creep = pwdata;
        HAMB_ACC_OFS:   if (pwdata != 32'h0) state_next.acc = pwdata;
        HAMB_RISE_OFS:  if (pwdata[11:0] <= HAMB_RISE_MAX && pwdata[31:12] == 20'h0)
                          state_next.rise = pwdata[11:0];
        HAMB_BSEL_OFS:  state_next.bsel = pwdata[10:0];
        HAMB_BDAT_OFS: begin
          for (int i = 0; i < 32; i++) begin
            if (bidx == 6'h00 || bidx == 6'(i + 1)) begin
              case (hamb_field_type'(state_reg.bsel[10:8]))
                HAMB_F_TGT:  state_next.tgt[i]   = pwdata;
                HAMB_F_SPD:  state_next.spd[i]   = pwdata;
                HAMB_F_ACC:  state_next.bacc[i]  = pwdata;
                HAMB_F_DEC:  state_next.bdec[i]  = pwdata;
                HAMB_F_MODE: state_next.bmode[i] = pwdata[7:0];
                HAMB_F_REPS: state_next.reps[i]  = pwdata[15:0];
                HAMB_F_NEXT: state_next.next[i]  = pwdata[5:0];
                HAMB_F_DSIG: state_next.dsig[i]  = pwdata[7:0];
                default:     state_next.tgt[i]   = state_reg.tgt[i];
              endcase
            end
          end
        end
        HAMB_MUX_OFS:   state_next.mux = pwdata[7:0];
        HAMB_ACT_OFS:   if (pwdata[5:0] != 6'h00 && pwdata[5:0] <= HAMB_BLK_COUNT)
                          state_next.act = pwdata[5:0];
        default:        state_next.mux = state_reg.mux;
      endcase
    end

    // ********** homing sequencer **********
    case (state_reg.st)
      HAMB_IDLE: begin
        state_next.spd_cmd = 32'h0000_0000;
        if (wr_en && paddr == HAMB_CTRL_OFS && pwdata[HAMB_CTRL_START_BIT]) begin
          if (state_reg.mode == HAMB_MODE_NONE || state_reg.mode == HAMB_MODE_ADOPT) begin
            state_next.home = act_pos;
            state_next.done = 1'b1;
          end else begin
            state_next.st   = HAMB_FAST;
            state_next.dir  = state_reg.mode[2];
            state_next.done = 1'b0;
            state_next.busy = 1'b1;
          end
        end
        if (wr_en && paddr == HAMB_CTRL_OFS && pwdata[HAMB_CTRL_ADOPT_BIT]) begin
          state_next.home = act_pos;
          state_next.done = 1'b1;
        end
      end
      HAMB_FAST: begin
        // dir 0 is clockwise (positive), dir 1 anticlockwise
        state_next.spd_cmd = state_reg.dir ? 32'(-state_reg.fast) : state_reg.fast;
        if (src_lvl) begin
          state_next.st  = HAMB_CREEP;
          state_next.dir = ~state_reg.dir;
        end else if ((state_reg.dir && state_reg.s2[0]) ||
                     (!state_reg.dir && state_reg.s2[1])) begin
          state_next.dir = ~state_reg.dir;
        end
      end
      HAMB_CREEP: begin
        state_next.spd_cmd = state_reg.dir ? 32'(-state_reg.creep) : state_reg.creep;
        if (src_edge) begin
          state_next.home = act_pos;
          state_next.st   = HAMB_DECEL;
        end
      end
      HAMB_DECEL: begin
        state_next.spd_cmd = 32'h0000_0000;
        if (axis_still) begin
          state_next.st   = HAMB_IDLE;
          state_next.busy = 1'b0;
          state_next.done = 1'b1;
        end
      end
      default: state_next.st = HAMB_IDLE;
    endcase
    // stop abandons the search; done stays low unless DECEL sees axis_still in the same cycle
    if (wr_en && paddr == HAMB_CTRL_OFS && pwdata[HAMB_CTRL_STOP_BIT] &&
        state_reg.st != HAMB_IDLE) begin
      state_next.st      = HAMB_IDLE;
      state_next.busy    = 1'b0;
      state_next.spd_cmd = 32'h0000_0000;
    end

    state_next.ref_pos = state_reg.home + state_reg.hofs;

    state_next.o_tgt  = state_reg.tgt[aidx];
    state_next.o_spd  = state_reg.spd[aidx];
    state_next.o_acc  = state_reg.bacc[aidx];
    state_next.o_dec  = state_reg.bdec[aidx];
    state_next.o_mode = state_reg.bmode[aidx];
    state_next.o_reps = state_reg.reps[aidx];
    state_next.o_next = state_reg.next[aidx];
    state_next.o_dsig = state_reg.dsig[aidx];
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg       <= '0;
      state_reg.st    <= HAMB_IDLE;
      state_reg.hofs  <= HAMB_HOFS_RST;
      state_reg.fast  <= HAMB_FAST_RST;
      state_reg.creep <= HAMB_CREEP_RST;
      state_reg.acc   <= HAMB_ACC_RST;
      state_reg.rise  <= HAMB_RISE_RST;
      state_reg.act   <= HAMB_ACT_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pready      = state_reg.pready;
  assign prdata      = state_reg.prdata;
  assign pslverr     = state_reg.pslverr;
  assign speed_cmd   = state_reg.spd_cmd;
  assign accel_cmd   = state_reg.acc;
  assign ramp_rise   = state_reg.rise;
  assign ref_pos     = state_reg.ref_pos;
  assign homing_done = state_reg.done;
  assign homing_busy = state_reg.busy;
  assign mux_idx     = state_reg.mux;
  assign blk_tgt     = state_reg.o_tgt;
  assign blk_spd     = state_reg.o_spd;
  assign blk_acc     = state_reg.o_acc;
  assign blk_dec     = state_reg.o_dec;
  assign blk_mode    = state_reg.o_mode;
  assign blk_reps    = state_reg.o_reps;
  assign blk_next    = state_reg.o_next;
  assign blk_dsig    = state_reg.o_dsig;

  // ************************************************************
  // checks
  // ************************************************************
  ref_sum_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 ref_pos == $past(state_reg.home) + $past(state_reg.hofs))
    else $error("reference is not home plus offset");

  fast_speed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg.st == HAMB_FAST && $past(state_reg.st) == HAMB_FAST |->
    speed_cmd == ($past(state_reg.dir) ? 32'(-$past(state_reg.fast)) : $past(state_reg.fast)))
    else $error("fast phase speed wrong");

  creep_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg.st == HAMB_FAST && src_lvl && !(wr_en && paddr == HAMB_CTRL_OFS)
    |=> state_reg.st == HAMB_CREEP ##1
    speed_cmd == (state_reg.dir ? 32'(-state_reg.creep) : state_reg.creep))
    else $error("creep phase not entered on reference level");

  start_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(homing_busy) |-> state_reg.dir == state_reg.mode[2] && state_reg.st == HAMB_FAST)
    else $error("start direction not taken from mode");

  latch_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg.st == HAMB_CREEP && src_edge && !(wr_en && paddr == HAMB_CTRL_OFS)
    |=> state_reg.home == $past(act_pos) && state_reg.st == HAMB_DECEL ##1 speed_cmd == 32'h0)
    else $error("home not latched on creep edge");

  done_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(homing_done) |-> $past(axis_still) || $past(state_reg.st) == HAMB_IDLE)
    else $error("done raised without a reference");

  accel_same_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    homing_busy && !(wr_en && paddr == HAMB_ACC_OFS) |=>
    accel_cmd == $past(accel_cmd) && accel_cmd != 32'h0)
    else $error("homing acceleration changed during a run");

  rise_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ramp_rise <= HAMB_RISE_MAX)
    else $error("ramp rise time out of range");

  bcast_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_en && paddr == HAMB_BDAT_OFS && bidx == 6'h00 &&
    state_reg.bsel[10:8] == HAMB_F_SPD |=>
    state_reg.spd[0] == $past(pwdata) && state_reg.spd[31] == $past(pwdata))
    else $error("index zero did not reach every block");

  mux_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(wr_en && paddr == HAMB_MUX_OFS) |=> $stable(mux_idx))
    else $error("mux index changed without its own write");

  apb_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    psel && penable && !pready |=> pready)
    else $error("slave did not answer in one wait cycle");

endmodule

// ---- sim/hamb_axis_model.sv ----
`timescale 1ns/1ns
// ************************************************************
// axis model: integrates the speed command, derives the switches
// ************************************************************
module hamb_axis_model
  import hamb_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] speed_cmd,
  output logic [31:0]      act_pos,
  output logic             axis_still,
  output logic             home_sw,
  output logic             enc_zero,
  output logic             lim_neg,
  output logic             lim_pos
);
  logic [2:0] still_cnt;
  // speed is scaled down so a homing run stays within a few hundred cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_pos   <= 32'h0000_0000;
      still_cnt <= 3'h0;
    end else begin
      act_pos   <= act_pos + 32'($signed(speed_cmd) >>> 10);
      still_cnt <= (speed_cmd != 32'h0) ? 3'h0 : ((still_cnt == 3'h7) ? 3'h7 : still_cnt + 3'h1);
    end
  end
  // stopping takes a few cycles, as a real drive would
  assign axis_still = (still_cnt == 3'h7);
  assign home_sw    = ($signed(act_pos) > 3000);
  assign enc_zero   = ($signed(act_pos) > 6000);
  assign lim_neg    = ($signed(act_pos) < -20000);
  assign lim_pos    = ($signed(act_pos) > 20000);
endmodule

// ---- sim/hamb_ctrl_tb_top.sv ----
`timescale 1ns/1ns
module hamb_ctrl_tb_top;
  import hamb_pkg::*;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        lim_neg, lim_pos, home_sw, enc_zero, axis_still, homing_done, homing_busy;
  logic [7:0]  paddr, mux_idx, blk_mode, blk_dsig;
  logic [31:0] pwdata, prdata, act_pos, speed_cmd, accel_cmd, ref_pos;
  logic [31:0] blk_tgt, blk_spd, blk_acc, blk_dec;
  logic [11:0] ramp_rise;
  logic [15:0] blk_reps;
  logic [5:0]  blk_next;
  logic [31:0] rd, home, hofs, v;
  logic [31:0] mdl [0:13];
  logic        err;
  int          fails = 0;
  int          checks = 0;
  int          thr [3] = '{3000, 6000, -20000};
  int          md [3] = '{10, 11, 12};
  logic [31:0] bv [8];
  logic [31:0] fm [8] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
                          32'h0000_00FF, 32'h0000_FFFF, 32'h0000_003F, 32'h0000_00FF};

  hamb_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lim_neg(lim_neg), .lim_pos(lim_pos), .home_sw(home_sw),
    .enc_zero(enc_zero), .act_pos(act_pos), .axis_still(axis_still), .speed_cmd(speed_cmd),
    .accel_cmd(accel_cmd), .ramp_rise(ramp_rise), .ref_pos(ref_pos),
    .homing_done(homing_done), .homing_busy(homing_busy), .mux_idx(mux_idx),
    .blk_tgt(blk_tgt), .blk_spd(blk_spd), .blk_acc(blk_acc), .blk_dec(blk_dec),
    .blk_mode(blk_mode), .blk_reps(blk_reps), .blk_next(blk_next), .blk_dsig(blk_dsig));

  hamb_axis_model axis (.sys_clk(sys_clk), .rst_n(rst_n), .speed_cmd(speed_cmd),
    .act_pos(act_pos), .axis_still(axis_still), .home_sw(home_sw), .enc_zero(enc_zero),
    .lim_neg(lim_neg), .lim_pos(lim_pos));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // pready is sampled at the rising edge, the same edge at which the write lands
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    if (k >= 50) chk("pready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick_until(input int c);
    int  k;
    logic hit;
    k = 0;
    hit = 1'b0;
    while (!hit && k < 3000) begin
      @(negedge sys_clk);
      k++;
      case (c)
        0: hit = ($signed(speed_cmd) < 0);
        1: hit = (speed_cmd != 32'h0);
        2: hit = (homing_done === 1'b1);
        4: hit = ($signed(speed_cmd) > 0);
        default: hit = (axis_still === 1'b1);
      endcase
    end
    if (!hit) chk("wait", 1, 0);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n = 1'b0;
    mdl = '{default: 32'h0};
    mdl[3] = 163840;
    mdl[4] = 32768;
    mdl[5] = 327680;
    mdl[13] = 1;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    v = $urandom(94);
    foreach (mdl[i]) if (i >= 1 && i <= 6 || i == 13) begin
      bus(0, 8'(i * 4), 0);
      chk("reset_reg", mdl[i], rd);
    end
    chk("accel_cmd", 32'h0005_0000, accel_cmd);
    bus(0, 8'h3C, 0);
    chk("unmapped_err", 1, {31'h0, err});
    bus(1, HAMB_FAST_OFS, 0);
    bus(1, HAMB_RISE_OFS, 2001);
    bus(1, HAMB_RISE_OFS, 2000);
    bus(0, HAMB_FAST_OFS, 0);
    chk("fast_min", 163840, rd);
    chk("ramp_rise", 2000, {20'h0, ramp_rise});
    hofs = -($urandom % 1000 + 1);
    bus(1, HAMB_HOFS_OFS, hofs);
    for (int m = 0; m < 3; m++) begin
      bus(1, HAMB_MODE_OFS, md[m]);
      bus(1, HAMB_CTRL_OFS, 1);
      tick_until(1);
      chk("fast_speed", md[m][2] ? -163840 : 163840, speed_cmd);
      tick_until(md[m][2] ? 4 : 0);
      chk("creep_speed", md[m][2] ? 32768 : -32768, speed_cmd);
      tick_until(2);
      chk("busy", 0, {31'h0, homing_busy});
      bus(0, HAMB_STAT_OFS, 0);
      chk("stat", md[m][2] ? 1 : 17, rd);
      bus(0, HAMB_HOME_OFS, 0);
      home = rd;
      v = ($signed(home) > thr[m] - 300 && $signed(home) < thr[m] + 300);
      chk("home_near", 1, v);
      chk("ref_pos", home + hofs, ref_pos);
      bus(0, HAMB_REF_OFS, 0);
      chk("ref_reg", home + hofs, rd);
      tick_until(3);
    end
    bus(1, HAMB_MODE_OFS, 10);
    bus(1, HAMB_CTRL_OFS, 1);
    bus(1, HAMB_CTRL_OFS, 4);
    repeat (2) @(negedge sys_clk);
    chk("stop_speed", 0, speed_cmd);
    chk("stop_done", 0, {31'h0, homing_done});
    tick_until(3);
    hofs = $urandom % 100000;
    bus(1, HAMB_HOFS_OFS, hofs);
    bus(1, HAMB_MODE_OFS, 35);
    bus(1, HAMB_CTRL_OFS, 1);
    repeat (3) @(negedge sys_clk);
    chk("adopt_done", 1, {31'h0, homing_done});
    chk("adopt_ref", act_pos + hofs, ref_pos);
    bus(1, HAMB_MODE_OFS, 10);
    bus(1, HAMB_CTRL_OFS, 1);
    bus(1, HAMB_CTRL_OFS, 4);
    tick_until(3);
    chk("adopt_bit_pre", 0, {31'h0, homing_done});
    bus(1, HAMB_CTRL_OFS, 2);
    bus(0, HAMB_HOME_OFS, 0);
    chk("adopt_bit_done", 1, {31'h0, homing_done});
    chk("adopt_bit_home", act_pos, rd);
    v = $urandom;
    bus(1, HAMB_BSEL_OFS, 32'h100);
    bus(1, HAMB_BDAT_OFS, v);
    bus(1, HAMB_ACT_OFS, 5);
    bus(1, HAMB_BSEL_OFS, 32'h405);
    bus(1, HAMB_BDAT_OFS, 1);
    bus(1, HAMB_MUX_OFS, 32'h5A);
    repeat (2) @(negedge sys_clk);
    chk("blk_spd_all", v, blk_spd);
    chk("blk_mode_one", 1, {24'h0, blk_mode});
    bus(1, HAMB_ACT_OFS, 32);
    repeat (2) @(negedge sys_clk);
    chk("blk_spd_last", v, blk_spd);
    chk("blk_mode_other", 0, {24'h0, blk_mode});
    chk("mux_idx", 32'h5A, {24'h0, mux_idx});
    bus(1, HAMB_ACT_OFS, 7);
    for (int f = 0; f < 8; f++) begin
      bv[f] = $urandom;
      bus(1, HAMB_BSEL_OFS, 32'((f << 8) | 7));
      bus(1, HAMB_BDAT_OFS, bv[f]);
      bus(0, HAMB_BDAT_OFS, 0);
      chk("blk_read", bv[f] & fm[f], rd);
    end
    repeat (2) @(negedge sys_clk);
    chk("blk_tgt", bv[0], blk_tgt);
    chk("blk_spd", bv[1], blk_spd);
    chk("blk_acc", bv[2], blk_acc);
    chk("blk_dec", bv[3], blk_dec);
    chk("blk_mode", bv[4] & fm[4], {24'h0, blk_mode});
    chk("blk_reps", bv[5] & fm[5], {16'h0, blk_reps});
    chk("blk_next", bv[6] & fm[6], {26'h0, blk_next});
    chk("blk_dsig", bv[7] & fm[7], {24'h0, blk_dsig});
    bus(1, HAMB_BSEL_OFS, 32'h21);
    bus(1, HAMB_BDAT_OFS, 7);
    chk("blk_range_err", 1, {31'h0, err});
    report_and_stop();
  end

  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
endmodule
